// file: src/pmus_regs.vh
// register offsets, field positions, reset values and timing for the sequencer
// assumes a 20 MHz sys_clk and a byte-wide register port
`ifndef PMUS_REGS_VH
`define PMUS_REGS_VH
`define PMUS_CLK_HZ 20000000
`define PMUS_OFF_REG_CTRL 8'h0a
`define PMUS_OFF_CMP_CTRL 8'h0b
`define PMUS_OFF_INT_EN 8'h0c
`define PMUS_OFF_INT_STAT 8'h0d
`define PMUS_OFF_INT_POL 8'h0e
`define PMUS_RST_REG_CTRL 8'h03
`define PMUS_RST_CMP_CTRL 8'h18
`define PMUS_RST_INT_EN 8'h00
`define PMUS_RST_INT_POL 8'h00
`define PMUS_BIT_EN1 0
`define PMUS_BIT_EN2 1
`define PMUS_BIT_HYST2 6
`define PMUS_CODE_MSB 5
`define PMUS_BIT_POL 0
`define PMUS_QUAL_MS 15
`define PMUS_GAP_MS 2
`define PMUS_INIT_MS 150
`define PMUS_SHUT_MS 4
`define PMUS_DIS_MS 14
`define PMUS_MIN_SLEEP_MS 12
`define PMUS_MS_CYCLES (`PMUS_CLK_HZ / 1000)
`endif

// file: src/pmus_ms_tick.v
// millisecond enable pulse divider
// assumes sys_clk at the rate given in the header
`timescale 1ns/1ns
`include "pmus_regs.vh"
module pmus_ms_tick #(
  parameter DIV = `PMUS_MS_CYCLES
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // running enable and tick
  input wire run,
  output reg tick
);
  reg [31:0] cnt_reg;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_reg == DIV - 1) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// file: src/pmus_ms_timer.v
// millisecond down counter, loaded then counts ticks to done
// assumes tick is a one-cycle pulse per millisecond
`timescale 1ns/1ns
module pmus_ms_timer (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // load and tick
  input wire load,
  input wire [7:0] load_ms,
  input wire tick,
  // status
  output wire done
);
  reg [7:0] cnt_reg;
  assign done = (cnt_reg == 8'h00);
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= load_ms;
    end else if (tick && !done) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

// file: src/pmus_sequencer.v
// power unit sequencer: start-up order, sleep handshake, faults, interrupt registers
// assumes analogue comparators arrive as levels synchronous to sys_clk
// Contract
// R1 - wait 15 ms after supply qualifies before configuring regulators
// R2 - regulator 1 bypass when option enabled and supply below 3.2 V
// R3 - start order 3, 1, 2 with 2 ms gap before each
// R4 - no enable input; sequence starts when supply is good
// R5 - software disables regulators 1 and 2 by control bits
// R6 - 150 ms quiet, then init released high, control mirrors request
// R7 - controller pulls init low; device then holds it low until reset
// R8 - rising request mirrored; sleep entered only if overrides and init low
// R9 - sleep entry shuts outputs over 4 ms, control low, active high
// R10 - request falling early keeps active high until discharge done
// R11 - request low and discharged: active low, restart in order
// R12 - short request releases after programmable 14 ms discharge time
// R13 - minimum sleep time of 12 ms always held; code ends sleep sooner when an override or init goes high
// R14 - override or init high during sleep ends it, control follows request
// R15 - under or overvoltage resets registers; overvoltage disables all regulators
// R16 - overtemperature resets everything, rerun power-up afterwards
// R17 - status shows live conditions, read does not clear
// R18 - status bits for regulator power-good flags and comparator
// R19 - each condition enabled by its own enable bit
// R20 - comparator threshold code resets to 6'h18
// R21 - polarity bit 0 sets comparator pin sense
// R22 - comparator control bit doubles falling hysteresis
// R23 - intervals counted from oscillator ticks; irq is or of enabled status
`timescale 1ns/1ns
`include "pmus_regs.vh"
module pmus_sequencer #(
  parameter MS_DIV = `PMUS_MS_CYCLES,
  parameter [7:0] DISCHARGE_MS = `PMUS_DIS_MS,
  parameter [7:0] MIN_SLEEP_MS = `PMUS_MIN_SLEEP_MS
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // supply and temperature monitors
  input wire supply_good,
  input wire overvoltage_lockout,
  input wire thermal_shutdown,
  input wire bypass_option,
  input wire vin_below_bypass,
  // regulator flags and comparator
  input wire [2:0] reg_pgood,
  input wire comp_above,
  // regulator controls
  output reg [2:0] reg_enable,
  output reg reg1_bypass,
  output reg osc_enable,
  // sleep pins
  input wire sleep_request_in,
  input wire sleep_override_1,
  input wire sleep_override_2,
  input wire init_pin_in,
  output reg init_pin_out,
  output reg init_pin_oe,
  output reg sleep_control_out,
  output reg sleep_control_oe,
  output reg sleep_active_out,
  // comparator setup and pins
  output reg [5:0] comp_code,
  output reg comp_hyst_double,
  output reg irq_out,
  output reg comp_pin_out,
  // register port
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata
);
  localparam S_OFF = 9'h001;
  localparam S_QUAL = 9'h002;
  localparam S_GAP3 = 9'h004;
  localparam S_GAP1 = 9'h008;
  localparam S_GAP2 = 9'h010;
  localparam S_RUN = 9'h020;
  localparam S_SHUT = 9'h040;
  localparam S_SLEEP = 9'h080;
  localparam S_WAKE = 9'h100;

  reg [8:0] state_reg;
  reg [8:0] state_next;
  reg [7:0] reg_ctrl_reg;
  reg [7:0] cmp_ctrl_reg;
  reg [7:0] int_en_reg;
  reg [7:0] int_pol_reg;
  reg init_done_reg;
  reg init_held_reg;
  reg init_prev_reg;
  reg req_prev_reg;
  reg load_seq;
  reg [7:0] load_ms;
  reg load_min;
  wire fault;
  wire soft_rst_b;
  wire tick;
  wire seq_done;
  wire min_done;
  wire init_window_done;
  wire gate_ok;
  wire [7:0] status;

  // faults hold the whole block in reset [R15] [R16]
  assign fault = !supply_good || overvoltage_lockout || thermal_shutdown;
  assign soft_rst_b = rst_b && !fault;
  assign gate_ok = !sleep_override_1 && !sleep_override_2 && !init_pin_in;
  // live, unlatched status [R17] [R18]
  assign status = {4'h0, comp_above, reg_pgood[2], reg_pgood[1], reg_pgood[0]};

  // millisecond tick, running everywhere but the off state [R23]
  pmus_ms_tick #(
    .DIV(MS_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_b(soft_rst_b),
    .run(state_reg != S_OFF),
    .tick(tick)
  );

  pmus_ms_timer u_seq (
    .sys_clk(sys_clk),
    .rst_b(soft_rst_b),
    .load(load_seq),
    .load_ms(load_ms),
    .tick(tick),
    .done(seq_done)
  );

  pmus_ms_timer u_init (
    .sys_clk(sys_clk),
    .rst_b(soft_rst_b),
    .load(state_reg == S_OFF),
    .load_ms(8'd`PMUS_INIT_MS),
    .tick(tick),
    .done(init_window_done)
  );

  pmus_ms_timer u_min (
    .sys_clk(sys_clk),
    .rst_b(soft_rst_b),
    .load(load_min),
    .load_ms(MIN_SLEEP_MS),
    .tick(tick),
    .done(min_done)
  );

  // sequence state machine
  always @* begin
    state_next = state_reg;
    load_seq = 1'b0;
    load_ms = 8'h00;
    load_min = 1'b0;
    case (state_reg)
      S_OFF: begin
        // automatic start, no enable pin [R4]
        state_next = S_QUAL;
        load_seq = 1'b1;
        load_ms = 8'd`PMUS_QUAL_MS;
      end
      S_QUAL: begin
        if (seq_done) begin
          // qualification delay done [R1]
          state_next = S_GAP3;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_GAP_MS;
        end
      end
      S_GAP3: begin
        if (seq_done) begin
          state_next = S_GAP1;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_GAP_MS;
        end
      end
      S_GAP1: begin
        if (seq_done) begin
          state_next = S_GAP2;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_GAP_MS;
        end
      end
      S_GAP2: begin
        if (seq_done) begin
          state_next = S_RUN;
        end
      end
      S_RUN: begin
        // entry gated by overrides and init pin [R8]
        if (init_done_reg && sleep_request_in && !req_prev_reg && gate_ok) begin
          state_next = S_SHUT;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_SHUT_MS;
          load_min = 1'b1;
        end
      end
      S_SHUT: begin
        if (!gate_ok) begin
          // override ends sleep [R14]
          state_next = S_GAP3;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_GAP_MS;
        end else if (seq_done) begin
          // timed shutdown of 4 ms [R9]
          state_next = S_SLEEP;
          load_seq = 1'b1;
          load_ms = DISCHARGE_MS;
        end
      end
      S_SLEEP: begin
        if (!gate_ok) begin
          state_next = S_GAP3;
          load_seq = 1'b1;
          load_ms = 8'd`PMUS_GAP_MS;
        end else if (!sleep_request_in && seq_done && min_done) begin
          // discharge and minimum sleep both honoured [R10] [R12] [R13]
          state_next = S_WAKE;
        end
      end
      S_WAKE: begin
        // restart in the normal order [R11]
        state_next = S_GAP3;
        load_seq = 1'b1;
        load_ms = 8'd`PMUS_GAP_MS;
      end
      default: begin
        state_next = S_OFF;
      end
    endcase
  end

  always @(posedge sys_clk or negedge soft_rst_b) begin
    if (!soft_rst_b) begin
      state_reg <= S_OFF;
      req_prev_reg <= 1'b0;
      init_prev_reg <= 1'b0;
      init_done_reg <= 1'b0;
      init_held_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_prev_reg <= sleep_request_in;
      init_prev_reg <= init_pin_in;
      if (init_window_done && state_reg != S_OFF) begin
        init_done_reg <= 1'b1;
      end
      // falling edge on the released init pin latches it low [R7]
      if (init_done_reg && init_prev_reg && !init_pin_in) begin
        init_held_reg <= 1'b1;
      end
    end
  end

  // regulator and pin outputs
  always @(posedge sys_clk or negedge soft_rst_b) begin
    if (!soft_rst_b) begin
      // all regulators off in any fault [R15] [R16]
      reg_enable <= 3'b000;
      reg1_bypass <= 1'b0;
      osc_enable <= 1'b1;
      init_pin_out <= 1'b0;
      init_pin_oe <= 1'b0;
      sleep_control_out <= 1'b0;
      sleep_control_oe <= 1'b0;
      sleep_active_out <= 1'b0;
    end else begin
      // bypass chosen when configuration is decided [R2]
      if (state_reg == S_QUAL && seq_done) begin
        reg1_bypass <= bypass_option && vin_below_bypass;
      end
      // staggered start 3, 1, 2 with software disables [R3] [R5]
      case (state_reg)
        S_OFF, S_QUAL, S_GAP3, S_SHUT, S_SLEEP, S_WAKE: begin
          reg_enable <= 3'b000;
        end
        S_GAP1: begin
          reg_enable <= 3'b100;
        end
        S_GAP2: begin
          reg_enable <= {1'b1, 1'b0, reg_ctrl_reg[`PMUS_BIT_EN1]};
        end
        default: begin
          reg_enable <= {1'b1, reg_ctrl_reg[`PMUS_BIT_EN2], reg_ctrl_reg[`PMUS_BIT_EN1]};
        end
      endcase
      osc_enable <= (state_reg != S_SLEEP);
      if (!init_done_reg) begin
        // quiet window: all sleep pins low or released [R6]
        init_pin_out <= 1'b0;
        init_pin_oe <= 1'b0;
        sleep_control_out <= 1'b0;
        sleep_control_oe <= 1'b0;
        sleep_active_out <= 1'b0;
      end else begin
        init_pin_out <= 1'b0;
        init_pin_oe <= init_held_reg;
        sleep_control_oe <= 1'b1;
        // active high through shutdown and sleep [R9] [R10]
        sleep_active_out <= (state_reg == S_SHUT || state_reg == S_SLEEP) && gate_ok;
        if ((state_reg == S_SHUT || state_reg == S_SLEEP) && gate_ok) begin
          sleep_control_out <= 1'b0;
        end else begin
          // mirror request otherwise [R6] [R8] [R14]
          sleep_control_out <= sleep_request_in;
        end
      end
    end
  end

  // register file, reset to its default values on any fault [R15] [R16]
  always @(posedge sys_clk or negedge soft_rst_b) begin
    if (!soft_rst_b) begin
      reg_ctrl_reg <= `PMUS_RST_REG_CTRL;
      cmp_ctrl_reg <= `PMUS_RST_CMP_CTRL;
      int_en_reg <= `PMUS_RST_INT_EN;
      int_pol_reg <= `PMUS_RST_INT_POL;
    end else if (reg_wr) begin
      case (reg_addr)
        `PMUS_OFF_REG_CTRL: reg_ctrl_reg <= {6'h00, reg_wdata[1:0]};
        `PMUS_OFF_CMP_CTRL: cmp_ctrl_reg <= {1'b0, reg_wdata[6:0]};
        `PMUS_OFF_INT_EN: int_en_reg <= {4'h0, reg_wdata[3:0]};
        `PMUS_OFF_INT_POL: int_pol_reg <= {7'h00, reg_wdata[0]};
        default: reg_ctrl_reg <= reg_ctrl_reg;
      endcase
    end
  end

  // read data and comparator outputs
  always @(posedge sys_clk or negedge soft_rst_b) begin
    if (!soft_rst_b) begin
      reg_rdata <= 8'h00;
      comp_code <= 6'h18;
      comp_hyst_double <= 1'b0;
      irq_out <= 1'b0;
      comp_pin_out <= 1'b1;
    end else begin
      case (reg_addr)
        `PMUS_OFF_REG_CTRL: reg_rdata <= reg_ctrl_reg;
        `PMUS_OFF_CMP_CTRL: reg_rdata <= cmp_ctrl_reg;
        `PMUS_OFF_INT_EN: reg_rdata <= int_en_reg;
        // read has no side effect [R17]
        `PMUS_OFF_INT_STAT: reg_rdata <= status;
        `PMUS_OFF_INT_POL: reg_rdata <= int_pol_reg;
        default: reg_rdata <= 8'h00;
      endcase
      // threshold code field [R20]
      comp_code <= cmp_ctrl_reg[`PMUS_CODE_MSB:0];
      // doubled falling hysteresis [R22]
      comp_hyst_double <= cmp_ctrl_reg[`PMUS_BIT_HYST2];
      // or of enabled live status [R19] [R23]
      irq_out <= |(status & int_en_reg);
      // polarity 0 gives low when above threshold [R21]
      comp_pin_out <= int_pol_reg[`PMUS_BIT_POL] ? comp_above : !comp_above;
    end
  end
endmodule

// file: dv/pmus_seq_chk_assertions.sv
// checker for the sequencer: start order, quiet window, init pin, sleep timing
// assumes it is bound to the sequencer top and sees only its ports
`timescale 1ns/1ns
module pmus_seq_chk #(
  parameter MS_DIV = 20
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_b,
  // faults
  input wire supply_good,
  input wire overvoltage_lockout,
  input wire thermal_shutdown,
  // regulators
  input wire [2:0] reg_enable,
  input wire osc_enable,
  // sleep pins
  input wire sleep_override_1,
  input wire sleep_override_2,
  input wire sleep_request_in,
  input wire init_pin_in,
  input wire init_pin_oe,
  input wire sleep_control_out,
  input wire sleep_control_oe,
  input wire sleep_active_out
);
  localparam int GAP_LO = MS_DIV + 1;
  localparam int QUIET = 150 * MS_DIV;
  localparam int START_LO = 15 * MS_DIV;
  localparam int MIN_SL = 12 * MS_DIV - 2;
  localparam int SHUT_MAX = 5 * MS_DIV;
  wire rst_any = !rst_b || !supply_good || overvoltage_lockout || thermal_shutdown;
  wire gate = sleep_override_1 || sleep_override_2 || init_pin_in;
  logic [15:0] up_cnt, act_cnt;
  logic gate_seen;
  // time since power-up, time asleep, gate seen while asleep
  always @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      up_cnt <= 16'h0000;
      act_cnt <= 16'h0000;
      gate_seen <= 1'b0;
    end else begin
      if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
      act_cnt <= sleep_active_out ? act_cnt + 16'h0001 : 16'h0000;
      gate_seen <= sleep_active_out && (gate_seen || gate);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst_any);
  sequence s_entry;
    $rose(sleep_active_out);
  endsequence
  sequence s_off;
    reg_enable == 3'b000 && !sleep_control_out;
  endsequence
  chk_shut_all_off: assert property (s_entry |-> ##[0:SHUT_MAX] s_off)
    else $error("outputs not off after sleep entry");
  chk_ctrl_low_sleep: assert property (sleep_active_out && !gate && !gate_seen
    |-> !sleep_control_out) else $error("control high while asleep");
  chk_osc_off_regs: assert property (!osc_enable |-> reg_enable == 3'b000)
    else $error("oscillator off with regulator on");
  chk_min_sleep: assert property ($fell(sleep_active_out) && !gate_seen
    |-> act_cnt >= MIN_SL) else $error("sleep shorter than minimum");
  chk_req_holds: assert property (sleep_active_out && sleep_request_in && !gate
    |=> sleep_active_out) else $error("sleep left with request high");
  chk_gate_exit: assert property (sleep_active_out && gate
    |-> ##[1:3] !sleep_active_out) else $error("override did not end sleep");
  chk_init_hold: assert property (init_pin_oe |=> init_pin_oe)
    else $error("init pin released before reset");
  chk_init_catch: assert property ($fell(init_pin_in) && sleep_control_oe && !init_pin_oe
    |-> ##[1:3] init_pin_oe) else $error("init low not latched");
  chk_quiet_win: assert property ((sleep_control_oe || init_pin_oe || sleep_active_out)
    |-> up_cnt >= QUIET) else $error("sleep pins active in quiet window");
  chk_start_late: assert property (reg_enable != 3'b000 |-> up_cnt >= START_LO)
    else $error("regulator on before qualification");
  chk_order_reg1: assert property ($rose(reg_enable[0]) |-> $past(reg_enable[2], GAP_LO))
    else $error("regulator 1 before regulator 3");
endmodule

// file: dv/pmus_ssd_model.sv
// controller model: sleep request, overrides and init pin pull-down
// assumes bench commands change just after a sys_clk edge
`timescale 1ns/1ns
module pmus_ssd_model (
  // bench commands
  input wire req_cmd,
  input wire pull_cmd,
  input wire [1:0] ovr_cmd,
  // device side
  input wire init_pin_oe,
  output wire sleep_request_in,
  output wire sleep_override_1,
  output wire sleep_override_2,
  output wire init_pin_in
);
  assign sleep_request_in = req_cmd;
  assign sleep_override_1 = ovr_cmd[0];
  assign sleep_override_2 = ovr_cmd[1];
  // pulled up, low when either party pulls down
  assign init_pin_in = !(init_pin_oe || pull_cmd);
endmodule

// file: dv/tb.sv
// testbench: start-up, registers, interrupt, init handshake, sleep and faults
// assumes a shortened millisecond divider and the controller model
`timescale 1ns/1ns
module tb;
  localparam int M = 20;
  logic sys_clk = 1'b0;
  logic rst_b, req, pull, comp_above, reg_wr, reg1_bypass, osc_enable;
  logic [1:0] ovr;
  logic [2:0] flt, reg_pgood, reg_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic init_pin_in, init_pin_oe, sleep_request_in, sleep_override_1, sleep_override_2;
  logic sleep_control_out, sleep_control_oe, sleep_active_out;
  logic [5:0] comp_code;
  logic comp_hyst_double, irq_out, comp_pin_out, byp, ipo;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0, tr;
  wire [4:0] mon = {sleep_control_oe, sleep_active_out, reg_enable};
  pmus_sequencer #(.MS_DIV(M)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .supply_good(!flt[0]),
    .overvoltage_lockout(flt[1]), .thermal_shutdown(flt[2]), .bypass_option(1'b1),
    .vin_below_bypass(byp), .reg_pgood(reg_pgood), .comp_above(comp_above),
    .reg_enable(reg_enable), .reg1_bypass(reg1_bypass), .osc_enable(osc_enable),
    .sleep_request_in(sleep_request_in), .sleep_override_1(sleep_override_1),
    .sleep_override_2(sleep_override_2), .init_pin_in(init_pin_in), .init_pin_out(ipo),
    .init_pin_oe(init_pin_oe), .sleep_control_out(sleep_control_out),
    .sleep_control_oe(sleep_control_oe), .sleep_active_out(sleep_active_out),
    .comp_code(comp_code), .comp_hyst_double(comp_hyst_double), .irq_out(irq_out),
    .comp_pin_out(comp_pin_out), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  pmus_ssd_model ssd_u (.req_cmd(req), .pull_cmd(pull), .ovr_cmd(ovr),
    .init_pin_oe(init_pin_oe), .sleep_request_in(sleep_request_in),
    .sleep_override_1(sleep_override_1), .sleep_override_2(sleep_override_2),
    .init_pin_in(init_pin_in));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 14000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic c1(logic seen, logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic rng(int v, int lo, int hi);
    c1(v >= lo && v <= hi, 1'b1);
  endtask
  task automatic wt(int b, logic v, int lim);
    for (int i = 0; i < lim && mon[b] !== v; i++) begin
      @(posedge sys_clk);
    end
    c1(mon[b], v);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    tick(2);
    chk(reg_rdata, exp);
  endtask
  task automatic tend(string s);
    $display("test %s done", s);
  endtask
  initial begin
    {rst_b, req, pull, ovr, comp_above, reg_wr, flt, reg_pgood} = '0;
    reg_addr = 8'h00;
    byp = 1'b1;
    reg_wdata = 8'h00;
    tick(3);
    rst_b <= 1'b1;
    tr = cyc;
    wt(2, 1'b1, 20 * M);
    rng(cyc - tr, 16 * M, 18 * M);
    t0 = cyc;
    wt(0, 1'b1, 3 * M);
    rng(cyc - t0, M + 1, 2 * M + 3);
    t0 = cyc;
    wt(1, 1'b1, 3 * M);
    rng(cyc - t0, M + 1, 2 * M + 3);
    c1(reg1_bypass, 1'b1);
    tend("startup");
    rdc(8'h0a, 8'h03);
    rdc(8'h0b, 8'h18);
    rdc(8'h0c, 8'h00);
    rdc(8'h0e, 8'h00);
    rdc(8'h20, 8'h00);
    wr(8'h0b, 8'h5f);
    rdc(8'h0b, 8'h5f);
    chk({2'b00, comp_code}, 8'h1f);
    c1(comp_hyst_double, 1'b1);
    wr(8'h0a, 8'h02);
    rdc(8'h0a, 8'h02);
    chk({5'h00, reg_enable}, 8'h06);
    wr(8'h0a, 8'h01);
    rdc(8'h0a, 8'h01);
    chk({5'h00, reg_enable}, 8'h05);
    wr(8'h0a, 8'h03);
    tend("registers");
    reg_pgood <= 3'b101;
    rdc(8'h0d, 8'h05);
    c1(irq_out, 1'b0);
    wr(8'h0c, 8'h04);
    rdc(8'h0d, 8'h05);
    c1(irq_out, 1'b1);
    wr(8'h0d, 8'h00);
    rdc(8'h0d, 8'h05);
    reg_pgood <= 3'b001;
    rdc(8'h0d, 8'h01);
    c1(irq_out, 1'b0);
    comp_above <= 1'b1;
    wr(8'h0c, 8'h08);
    rdc(8'h0d, 8'h09);
    c1(irq_out, 1'b1);
    c1(comp_pin_out, 1'b0);
    wr(8'h0e, 8'h01);
    rdc(8'h0e, 8'h01);
    c1(comp_pin_out, 1'b1);
    comp_above <= 1'b0;
    tick(3);
    c1(comp_pin_out, 1'b0);
    tend("interrupt");
    wt(4, 1'b1, 160 * M);
    rng(cyc - tr, 150 * M, 152 * M);
    c1(init_pin_in, 1'b1);
    req <= 1'b1;
    tick(4);
    c1(sleep_control_out, 1'b1);
    c1(sleep_active_out, 1'b0);
    req <= 1'b0;
    pull <= 1'b1;
    tick(3);
    pull <= 1'b0;
    tick(3);
    c1(init_pin_oe, 1'b1);
    c1(init_pin_in, 1'b0);
    c1(ipo, 1'b0);
    tend("init");
    req <= 1'b1;
    wt(3, 1'b1, 5 * M);
    tick(5 * M);
    chk({5'h00, reg_enable}, 8'h00);
    c1(osc_enable, 1'b0);
    c1(sleep_control_out, 1'b0);
    tick(20 * M);
    req <= 1'b0;
    wt(3, 1'b0, 4);
    wt(2, 1'b1, 3 * M);
    chk({5'h00, reg_enable}, 8'h04);
    wt(1, 1'b1, 5 * M);
    req <= 1'b1;
    wt(3, 1'b1, 5 * M);
    t0 = cyc;
    tick(2 * M);
    req <= 1'b0;
    tick(9 * M);
    c1(sleep_active_out, 1'b1);
    wt(3, 1'b0, 12 * M);
    rng(cyc - t0, 12 * M, 19 * M);
    wt(1, 1'b1, 8 * M);
    tend("sleep");
    for (int i = 1; i < 3; i++) begin
      req <= 1'b1;
      wt(3, 1'b1, 5 * M);
      tick(5 * M);
      ovr <= i[1:0];
      wt(3, 1'b0, 4);
      c1(sleep_control_out, 1'b1);
      ovr <= 2'b00;
      req <= 1'b0;
      wt(1, 1'b1, 8 * M);
    end
    tend("override");
    for (int f = 0; f < 3; f++) begin
      wr(8'h0c, 8'h0f);
      flt <= 3'b001 << f;
      byp <= (f != 1);
      tick(3);
      chk({5'h00, reg_enable}, 8'h00);
      flt <= 3'b000;
      rdc(8'h0c, 8'h00);
      wt(2, 1'b1, 20 * M);
      c1(reg1_bypass, f != 1);
    end
    tend("faults");
    complete_run();
  end
endmodule
bind pmus_sequencer pmus_seq_chk #(.MS_DIV(MS_DIV)) chk_u (.sys_clk, .rst_b,
  .supply_good, .overvoltage_lockout, .thermal_shutdown, .reg_enable, .osc_enable,
  .sleep_override_1, .sleep_override_2, .sleep_request_in, .init_pin_in, .init_pin_oe,
  .sleep_control_out, .sleep_control_oe, .sleep_active_out);
